// file: src/quad_counter_timer_pwm.sv
// Purpose: four 8-bit counter/timers, pairable, with capture and pwm
// Assumes: clock sources sampled on clk, far slower than clk
// Notes: counters step on detected rising edges of their source
`include "quad_counter_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module quad_counter_timer_pwm (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire quad_counter_pkg::apb_req_type apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter clock and capture sources
    input wire quad_counter_pkg::clk_src_type clkSrc,
    // interrupt and event lines
    output logic [3:0] intLine,
    output logic [7:0] intBankUpper,
    output logic [7:0] intBankLower,
    output logic [7:0] eventBank,
    // pwm port outputs
    output logic [1:0] pulsePin,
    output logic [1:0] pulseOverride
);
    quad_counter_pkg::state_type s;
    quad_counter_pkg::state_type n;
    logic [3:0] tickVec;
    logic [3:0] fallVec;
    logic [3:0] termVec;
    logic capEv;

    // source select per counter
    function automatic logic pick(input logic [1:0] sel,
        input logic [1:0] idx, input logic [7:0] ev, input logic q);
        case (sel)
            2'b00: pick = ev[idx];
            2'b01: pick = idx[1] ? ev[5] : ev[4];
            2'b10: pick = idx[1] ? ev[6] : q;
            default: pick = ev[7];
        endcase
    endfunction

    always_comb begin
        logic [7:0] raw;
        logic [7:0] rise;
        logic [7:0] fall;
        logic qRise;
        logic qFall;
        logic capRaw;
        logic capOn;
        logic casc;
        logic pwm;
        logic up;
        logic cp;
        logic tk;
        logic fk;
        logic term;
        logic wr;
        logic mapped;
        logic [3:0] irq;
        logic [15:0] v;
        logic [15:0] t;
        logic [15:0] m;
        logic [2:0] idx;
        logic [1:0] sz;
        int l;
        int j;
        n = s;
        raw = clkSrc;
        rise = raw & ~s.prevSrc;
        fall = ~raw & s.prevSrc;
        qRise = rise[4] && s.rcDiv == 2'd3;
        qFall = rise[4] && s.rcDiv == 2'd1;
        capRaw = 1'b0;
        capOn = s.configTwoReg[`QC_CFG2_CAPFUNC+:2] != 2'b00;
        casc = 1'b0;
        pwm = 1'b0;
        up = 1'b0;
        cp = 1'b0;
        tk = 1'b0;
        fk = 1'b0;
        term = 1'b0;
        irq = 4'h0;
        v = 16'h0000;
        t = 16'h0000;
        m = 16'h0000;
        sz = 2'b00;
        l = 0;
        j = 0;
        idx = 3'h0;
        wr = 1'b0;
        mapped = 1'b0;
        tickVec = 4'h0;
        fallVec = 4'h0;
        termVec = 4'h0;
        n.prevSrc = raw;
        if (rise[4]) begin
            n.rcDiv = s.rcDiv + 2'd1;
        end
        case (s.configTwoReg[`QC_CFG2_CAPSEL+:2])
            2'b11: capRaw = raw[6];
            2'b10: capRaw = raw[5];
            2'b01: capRaw = raw[3];
            default: capRaw = raw[2];
        endcase
        // toggling capture may let a stray edge through [RULE16]
        n.prevCap = capRaw;
        capEv = capOn && ((s.configTwoReg[`QC_CFG2_CAPFUNC] && capRaw
            && !s.prevCap) || (s.configTwoReg[`QC_CFG2_CAPFUNC+1]
            && !capRaw && s.prevCap));
        if (capEv) begin
            n.shadow = {s.count[1], s.count[0]};
        end
        for (int k = 0; k < 4; k++) begin
            tickVec[k] = pick(s.clockSelectReg[2*k+:2], 2'(k), rise,
                qRise) && s.counterRunControl[k]; // [RULE12] [RULE5]
            fallVec[k] = pick(s.clockSelectReg[2*k+:2], 2'(k), fall,
                qFall) && s.counterRunControl[k]; // [RULE2]
        end
        for (int p = 0; p < 2; p++) begin
            l = 2 * p;
            casc = s.configOneReg[`QC_CFG1_CASC+p];
            pwm = s.configOneReg[p];
            up = s.configOneReg[`QC_CFG1_DIR+l] && !pwm;
            sz = s.configTwoReg[2*p+:2];
            m = 16'hffff >> (6 - 2 * sz);
            if (casc) begin
                // low byte a/c, high byte b/d [RULE15]
                v = {s.count[l+1], s.count[l]};
                t = {s.target[l+1], s.target[l]};
                tk = tickVec[l];
                fk = fallVec[l]; // [RULE2]
                cp = capOn && p == 0 && !pwm;
                term = up ? v == t : v == 16'h0000; // [RULE18]
                termVec[l] = term;
                n.pulse[p] = (v & m) <= t; // [RULE19] [RULE23]
                if (tk && (s.pendLoad[l] || s.pendLoad[l+1])) begin
                    if (s.pendLoad[l]) begin
                        v[7:0] = up ? 8'h00 : t[7:0]; // [RULE9]
                    end
                    if (s.pendLoad[l+1]) begin
                        v[15:8] = up ? 8'h00 : t[15:8];
                    end
                    n.pendLoad[l] = 1'b0;
                    n.pendLoad[l+1] = 1'b0;
                end else if (tk) begin
                    if (!pwm && !cp && term) begin
                        v = up ? 16'h0000 : t; // [RULE22]
                    end else begin
                        v = up ? v + 16'h0001 : v - 16'h0001; // [RULE24]
                    end
                end
                n.count[l] = v[7:0];
                n.count[l+1] = v[15:8];
                irq[l] = !pwm && !cp && fk && term; // [RULE22]
                if (cp && capEv) begin
                    irq[l] = 1'b1; // [RULE20]
                    irq[l+1] = 1'b1;
                end
            end else begin
                n.pulse[p] = s.count[l] <= s.target[l]; // [RULE23]
                for (int k = 0; k < 2; k++) begin
                    j = l + k;
                    tk = tickVec[j];
                    fk = fallVec[j];
                    up = s.configOneReg[`QC_CFG1_DIR+j] && !(pwm && k == 0);
                    cp = capOn && p == 0 && !(pwm && k == 0); // [RULE14]
                    term = up ? s.count[j] == s.target[j]
                        : s.count[j] == 8'h00;
                    termVec[j] = term;
                    if (tk && s.pendLoad[j]) begin
                        n.count[j] = up ? 8'h00 : s.target[j]; // [RULE7]
                        n.pendLoad[j] = 1'b0; // [RULE8] [RULE9]
                    end else if (tk) begin
                        if ((pwm && k == 0) || cp || !term) begin
                            n.count[j] = up ? s.count[j] + 8'h01
                                : s.count[j] - 8'h01;
                        end else begin
                            n.count[j] = up ? 8'h00 : s.target[j];
                        end
                    end
                    // pwm counter gives no interrupt [RULE19] [RULE17]
                    irq[j] = !(pwm && k == 0) && !cp && fk && term;
                    if (cp && capEv) begin
                        irq[j] = 1'b1; // [RULE20]
                    end
                end
            end
            n.override[p] = pwm; // [RULE21]
            if (!pwm) begin
                n.pulse[p] = 1'b0;
            end
        end
        n.intLine = irq;
        n.intUpper = 8'h00;
        n.intLower = 8'h00;
        n.eventBits = 8'h00;
        n.intUpper[`QC_UPPER_A] = irq[0]; // [RULE1]
        n.intUpper[`QC_UPPER_C] = irq[2];
        n.intLower[`QC_LOWER_B] = irq[1];
        n.intLower[`QC_LOWER_D] = irq[3];
        n.eventBits[`QC_EVT_A] = irq[0];
        n.eventBits[`QC_EVT_B] = irq[1];
        n.eventBits[`QC_EVT_C] = irq[2];
        n.eventBits[`QC_EVT_D] = irq[3];
        // apb: one wait state, answer on second access cycle
        idx = apbReq.paddr[4:2];
        mapped = apbReq.paddr[7:5] == 3'h0 && apbReq.paddr[1:0] == 2'h0;
        wr = apbReq.psel && apbReq.penable && s.ready && apbReq.pwrite
            && mapped;
        n.ready = apbReq.psel && apbReq.penable && !s.ready;
        n.slverr = n.ready && !mapped;
        n.rdata = 32'h0000_0000;
        if (n.ready && mapped && !apbReq.pwrite) begin
            case (idx)
                `QC_OFS_CLKSEL: n.rdata[7:0] = s.clockSelectReg;
                `QC_OFS_CFG1: n.rdata[7:0] = s.configOneReg;
                `QC_OFS_CFG2: n.rdata[7:0] = s.configTwoReg;
                `QC_OFS_RUN: n.rdata[3:0] = s.counterRunControl;
                default: begin
                    n.rdata[7:0] = (capOn && !idx[1]) ? s.shadow[idx[0]]
                        : s.count[idx[1:0]]; // [RULE4]
                end
            endcase
        end
        if (wr) begin
            case (idx)
                `QC_OFS_CLKSEL: n.clockSelectReg = apbReq.pwdata[7:0];
                `QC_OFS_CFG1: n.configOneReg = apbReq.pwdata[7:0];
                `QC_OFS_CFG2: n.configTwoReg = apbReq.pwdata[7:0];
                `QC_OFS_RUN: n.counterRunControl = apbReq.pwdata[3:0];
                default: begin
                    n.target[idx[1:0]] = apbReq.pwdata[7:0]; // [RULE4]
                    // pwm counters keep count on write [RULE10] [RULE11]
                    if (!(s.configOneReg[idx[1]] && (!idx[0]
                        || s.configOneReg[`QC_CFG1_CASC+idx[1]]))) begin
                        n.pendLoad[idx[1:0]] = 1'b1; // [RULE7] [RULE8]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.clockSelectReg <= `QC_CLKSEL_RST;
            s.configOneReg <= `QC_CFG1_RST;
            s.configTwoReg <= `QC_CFG2_RST;
            s.counterRunControl <= `QC_RUN_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;
    assign intLine = s.intLine;
    assign intBankUpper = s.intUpper;
    assign intBankLower = s.intLower;
    assign eventBank = s.eventBits;
    assign pulsePin = s.pulse;
    assign pulseOverride = s.override;

    // checks
    logic wrA;
    logic wrCfg;
    logic cascAB;
    logic capOnChk;
    assign wrA = apbReq.psel && apbReq.penable && s.ready && apbReq.pwrite
        && apbReq.paddr == 8'h00;
    assign wrCfg = apbReq.psel && apbReq.penable && s.ready
        && apbReq.pwrite && apbReq.paddr == 8'h14;
    assign cascAB = s.configOneReg[`QC_CFG1_CASC];
    assign capOnChk = s.configTwoReg[`QC_CFG2_CAPFUNC+:2] != 2'b00;

    sequence termFallA;
        fallVec[0] && termVec[0] && !cascAB && !capOnChk
            && !s.configOneReg[0];
    endsequence
    sequence irqRaisedA;
        intLine[0] && intBankUpper[`QC_UPPER_A];
    endsequence

    irq_map_a: assert property (@(posedge clk) disable iff (rst)
        intLine[0] == eventBank[`QC_EVT_A] && intLine[1]
        == intBankLower[`QC_LOWER_B] && intLine[2]
        == intBankUpper[`QC_UPPER_C]) // [RULE1]
        else $error("interrupt line not mapped to bank bit");
    stop_freeze_a: assert property (@(posedge clk) disable iff (rst)
        !s.counterRunControl[0] |=> $stable(s.count[0])) // [RULE5]
        else $error("stopped counter a changed");
    up_write_a: assert property (@(posedge clk) disable iff (rst)
        wrA && !s.configOneReg[0] |=> s.pendLoad[0]
        && s.target[0] == $past(apbReq.pwdata[7:0])) // [RULE7]
        else $error("counter write did not arm load");
    down_load_a: assert property (@(posedge clk) disable iff (rst)
        s.pendLoad[0] && tickVec[0] && !cascAB && !s.configOneReg[4]
        |=> s.count[0] == $past(s.target[0])) // [RULE8]
        else $error("downcount load missed");
    pwm_noload_a: assert property (@(posedge clk) disable iff (rst)
        wrA && s.configOneReg[0] && !s.pendLoad[0] |=> !s.pendLoad[0])
        // [RULE10]
        else $error("pwm write armed a load");
    mode_noload_a: assert property (@(posedge clk) disable iff (rst)
        wrCfg && !s.pendLoad[0] |=> !s.pendLoad[0]) // [RULE11]
        else $error("mode change armed a load");
    pwm_level_a: assert property (@(posedge clk) disable iff (rst)
        s.configOneReg[0] && !cascAB |=> pulsePin[0]
        == ($past(s.count[0]) <= $past(s.target[0]))) // [RULE23]
        else $error("pwm level wrong");
    pwm_quiet_a: assert property (@(posedge clk) disable iff (rst)
        s.configOneReg[0] && $past(s.configOneReg[0]) |-> !intLine[0])
        // [RULE19]
        else $error("pwm counter raised interrupt");
    casc_quiet_a: assert property (@(posedge clk) disable iff (rst)
        cascAB && !capOnChk && $past(cascAB && !capOnChk) |-> !intLine[1])
        // [RULE18]
        else $error("cascaded high counter raised interrupt");
    fall_irq_a: assert property (@(posedge clk) disable iff (rst)
        termFallA |=> irqRaisedA) // [RULE22]
        else $error("no interrupt at falling edge on terminal");
endmodule // quad_counter_timer_pwm
`default_nettype wire

// file: common/quad_counter_regs.svh
// Purpose: offsets, field positions, reset values of the counter block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: 8-bit registers sit in the low bits, upper bits read zero
// Function
// [RULE1] route interrupt lines to fixed bank bits
// [RULE2] counters run only while enabled
// [RULE3] software programs clock, config, counters in order
// [RULE4] read gives count or capture; write sets compare
// [RULE5] stopped counter freezes, ignores clock edges
// [RULE6] software reads running counters by safe method
// [RULE7] upcount write clears running count
// [RULE8] downcount write loads compare into count
// [RULE9] count change waits for first enabled edge
// [RULE10] pwm write leaves running count alone
// [RULE11] mode change never reloads the count
// [RULE12] two-bit clock selector decode per counter
// [RULE13] software changes clock source only when stopped
// [RULE14] counter, captured counter, down-only pwm modes
// [RULE15] a and c low byte, b and d high
// [RULE16] switch modes stopped; capture toggling may interrupt
// [RULE17] uncascaded pair: independent counters, port normal
// [RULE18] cascade: low direction, low interrupt only
// [RULE19] pwm: eight bit or cascaded pwm, no interrupt
// [RULE20] capture: captured counters raise capture interrupts
// [RULE21] c/d pair same matrix without capture
// [RULE22] interrupt at falling edge, reload on rising
// [RULE23] pwm high when count not above code
// [RULE24] cascaded high byte advances on low wrap
`ifndef QUAD_COUNTER_REGS_SVH
`define QUAD_COUNTER_REGS_SVH
`define QC_OFS_CNT_A 3'h0
`define QC_OFS_CNT_B 3'h1
`define QC_OFS_CNT_C 3'h2
`define QC_OFS_CNT_D 3'h3
`define QC_OFS_CLKSEL 3'h4
`define QC_OFS_CFG1 3'h5
`define QC_OFS_CFG2 3'h6
`define QC_OFS_RUN 3'h7
`define QC_CFG1_DIR 4
`define QC_CFG1_CASC 2
`define QC_CFG2_CAPFUNC 4
`define QC_CFG2_CAPSEL 6
`define QC_UPPER_A 4
`define QC_UPPER_C 3
`define QC_LOWER_B 5
`define QC_LOWER_D 4
`define QC_EVT_A 7
`define QC_EVT_B 3
`define QC_EVT_C 6
`define QC_EVT_D 2
`define QC_CLKSEL_RST 8'h00
`define QC_CFG1_RST 8'h00
`define QC_CFG2_RST 8'h00
`define QC_RUN_RST 4'h0
`endif

// file: common/quad_counter_pkg.sv
// Purpose: types of the counter block
// Assumes: constants live in quad_counter_regs.svh
// Notes: whole block state is one packed struct
package quad_counter_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;
    // ext pins 3:0, rc, 32k, 1k, 128hz
    typedef struct packed {
        logic slow128hzClock;
        logic clock1khz;
        logic clock32khz;
        logic rcOscClock;
        logic [3:0] extClockPin;
    } clk_src_type;
    typedef struct packed {
        logic [3:0][7:0] count;
        logic [3:0][7:0] target;
        logic [1:0][7:0] shadow;
        logic [7:0] clockSelectReg;
        logic [7:0] configOneReg;
        logic [7:0] configTwoReg;
        logic [3:0] counterRunControl;
        logic [3:0] pendLoad;
        logic [7:0] prevSrc;
        logic [1:0] rcDiv;
        logic prevCap;
        logic [3:0] intLine;
        logic [7:0] intUpper;
        logic [7:0] intLower;
        logic [7:0] eventBits;
        logic [1:0] pulse;
        logic [1:0] override;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_type;
endpackage

// file: testbench/clock_source_model.sv
// Purpose: far-side model of the counter clock and capture sources
// Assumes: every source idles low and stands still between periods
// Notes: a hold of 2 is the fastest period, larger holds are slow
`timescale 1ns/100ps
`default_nettype none
module clock_source_model (
    // clock
    input wire logic clk,
    // source lines: pins 3:0, rc, 32k, 1k, 128hz
    output var quad_counter_pkg::clk_src_type clkSrc
);
    logic [7:0] lines = 8'h00;
    assign clkSrc = lines;
    // one period on one line: rise, hold, fall, hold
    task automatic tick(input int idx, input int hold);
        @(posedge clk);
        lines[idx] <= 1'b1;
        repeat (hold) @(posedge clk);
        lines[idx] <= 1'b0;
        repeat (hold) @(posedge clk);
    endtask
endmodule // clock_source_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the quad counter/timer block
// Assumes: counts are read only while the sources stand still
// Notes: random targets, directions and periods from a fixed seed
`include "quad_counter_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    quad_counter_pkg::apb_req_type apbReq = '0;
    quad_counter_pkg::clk_src_type clkSrc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] intLine;
    logic [7:0] intBankUpper;
    logic [7:0] intBankLower;
    logic [7:0] eventBank;
    logic [1:0] pulsePin;
    logic [1:0] pulseOverride;
    logic [23:0] banks;
    logic [31:0] rdata;
    logic rerr;
    int nMismatch = 0;
    int checksDone = 0;
    int seed = 72;
    int intCount [4] = '{0, 0, 0, 0};
    assign banks = {intBankUpper, intBankLower, eventBank};
    quad_counter_timer_pwm dut (.clk(clk), .rst(rst), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clkSrc(clkSrc), .intLine(intLine), .intBankUpper(intBankUpper),
        .intBankLower(intBankLower), .eventBank(eventBank),
        .pulsePin(pulsePin), .pulseOverride(pulseOverride));
    clock_source_model src (.clk(clk), .clkSrc(clkSrc));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic conclude();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic checkVal(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkBit(input string what, input logic exp,
        input logic got);
        checkVal(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
    endtask
    // apb master: setup, access, wait for pready, one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        checkBit("pready", 1'b1, pready);
        rdata = prdata;
        rerr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        apb(1'b1, {3'h0, i, 2'h0}, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [2:0] i, input string what,
        input logic [7:0] exp);
        apb(1'b0, {3'h0, i, 2'h0}, 32'h0000_0000);
        checkBit("err", 1'b0, rerr);
        checkVal(what, {24'h00_0000, exp}, rdata);
    endtask
    task automatic tk(input int idx, input int n);
        repeat (n) src.tick(idx, 2 + ($random(seed) & 3));
    endtask
    function automatic int expCount(input logic up, input int t,
        input int m);
        int p;
        p = m % (t + 1);
        return up ? p : t - p;
    endfunction
    function automatic int expInts(input int t, input int m);
        return (m + 1) / (t + 1);
    endfunction
    function automatic int srcIndex(input int i, input int code);
        case (code)
            0: return i;
            1: return (i < 2) ? 4 : 5;
            2: return (i < 2) ? 4 : 6;
            default: return 7;
        endcase
    endfunction
    function automatic logic [23:0] bankMap(input logic [3:0] q);
        logic [23:0] b;
        b = 24'h00_0000;
        b[20] = q[0];
        b[19] = q[2];
        b[13] = q[1];
        b[12] = q[3];
        b[7] = q[0];
        b[3] = q[1];
        b[6] = q[2];
        b[2] = q[3];
        return b;
    endfunction
    always @(posedge clk) begin
        for (int j = 0; j < 4; j++)
            if (intLine[j] === 1'b1)
                intCount[j]++;
        if (!rst && {intLine, banks} !== 28'h000_0000)
            checkVal("int map", 32'(bankMap(intLine)), 32'(banks));
    end
    task automatic singleRun(input int i, input int code);
        logic up;
        int t;
        int m;
        int k;
        int c;
        up = 1'($random(seed));
        t = 1 + ($random(seed) & 7);
        m = 2 + ($random(seed) & 15);
        k = (code == 2 && i < 2) ? 4 : 1;
        c = expCount(up, t, m);
        wr(`QC_OFS_RUN, 8'h00);
        wr(`QC_OFS_CLKSEL, 8'(code << (2 * i)));
        wr(`QC_OFS_CFG1, 8'(int'(up) << (4 + i)));
        wr(`QC_OFS_CFG2, 8'h00);
        wr(3'(i), 8'(t));
        intCount = '{0, 0, 0, 0};
        wr(`QC_OFS_RUN, 8'(1 << i));
        tk(srcIndex(i, code), (m + 1) * k);
        wr(`QC_OFS_RUN, 8'h00);
        rd(3'(i), "count", 8'(c));
        for (int j = 0; j < 4; j++)
            if (k == 1 || j != i)
                checkVal("ints", (j == i) ? expInts(t, m) : 0, intCount[j]);
        wr(`QC_OFS_CFG1, 8'(int'(!up) << (4 + i)));
        tk(srcIndex(i, code), 2 * k);
        rd(3'(i), "frozen", 8'(c));
        checkVal("override", 32'h0000_0000, 32'(pulseOverride));
    endtask
    task automatic cascadeRun(input int p);
        logic up;
        int t;
        int m;
        int c;
        int cfg;
        up = 1'($random(seed));
        t = 256 + ($random(seed) & 3);
        m = 256 + ($random(seed) & 63);
        c = expCount(up, t, m);
        cfg = (int'(up) << (4 + 2 * p)) | (int'(!up) << (5 + 2 * p));
        wr(`QC_OFS_RUN, 8'h00);
        wr(`QC_OFS_CLKSEL, 8'h00);
        wr(`QC_OFS_CFG1, 8'(cfg | (4 << p)));
        wr(`QC_OFS_CFG2, 8'h00);
        wr(3'(2 * p), 8'(t));
        wr(3'(2 * p + 1), 8'(t >> 8));
        intCount = '{0, 0, 0, 0};
        wr(`QC_OFS_RUN, 8'(1 << (2 * p)));
        tk(2 * p, m + 1);
        wr(`QC_OFS_RUN, 8'h00);
        rd(3'(2 * p), "cascade low", 8'(c));
        rd(3'(2 * p + 1), "cascade high", 8'(c >> 8));
        checkVal("low int", expInts(t, m), intCount[2 * p]);
        checkVal("high int", 32'h0000_0000, intCount[2 * p + 1]);
    endtask
    task automatic pwmRun(input int p);
        int c;
        logic [7:0] code;
        wr(`QC_OFS_RUN, 8'h00);
        wr(`QC_OFS_CLKSEL, 8'h00);
        wr(`QC_OFS_CFG1, 8'(1 << p));
        wr(`QC_OFS_CFG2, 8'h00);
        apb(1'b0, 8'(8 * p), 32'h0000_0000);
        c = int'(rdata[7:0]);
        code = 8'(c - 3);
        wr(3'(2 * p), code);
        rd(3'(2 * p), "pwm count", 8'(c));
        intCount = '{0, 0, 0, 0};
        wr(`QC_OFS_RUN, 8'(1 << (2 * p)));
        repeat (7) begin
            src.tick(2 * p, 2);
            c = (c + 255) & 255;
            checkBit("pwm level", c <= code, pulsePin[p]);
        end
        checkBit("pwm override", 1'b1, pulseOverride[p]);
        checkVal("pwm int", 32'h0000_0000, intCount[2 * p]);
    endtask
    task automatic captureRun();
        wr(`QC_OFS_RUN, 8'h00);
        wr(`QC_OFS_CLKSEL, 8'h00);
        wr(`QC_OFS_CFG1, 8'h30);
        wr(`QC_OFS_CFG2, 8'hD0);
        wr(3'h0, 8'hFF);
        wr(3'h1, 8'hFF);
        intCount = '{0, 0, 0, 0};
        wr(`QC_OFS_RUN, 8'h03);
        tk(0, 4);
        tk(1, 6);
        tk(6, 1);
        tk(0, 2);
        rd(3'h0, "capture a", 8'h03);
        rd(3'h1, "capture b", 8'h05);
        checkVal("cap int a", 32'h0000_0001, intCount[0]);
        checkVal("cap int b", 32'h0000_0001, intCount[1]);
        tk(6, 1);
        rd(3'h0, "capture a2", 8'h05);
        wr(`QC_OFS_RUN, 8'h00);
    endtask
    initial begin
        logic [7:0] v;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 8; r++)
            rd(3'(r), "reset", 8'h00);
        apb(1'b1, 8'h20, 32'h0000_00FF);
        checkBit("err wr", 1'b1, rerr);
        apb(1'b0, 8'h06, 32'h0000_0000);
        checkBit("err rd", 1'b1, rerr);
        checkVal("err data", 32'h0000_0000, rdata);
        v = 8'($random(seed));
        wr(`QC_OFS_CLKSEL, v);
        rd(`QC_OFS_CLKSEL, "clksel", v);
        wr(`QC_OFS_RUN, 8'hFF);
        rd(`QC_OFS_RUN, "run", 8'h0F);
        for (int i = 0; i < 4; i++)
            for (int code = 0; code < 4; code++)
                singleRun(i, code);
        cascadeRun(0);
        cascadeRun(1);
        pwmRun(0);
        pwmRun(1);
        captureRun();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clk);
        nMismatch++;
        conclude();
    end
endmodule // testbench
`default_nettype wire
